// >>> design/stream_write_pkg.sv
// constants and types for the stream dma write command block
package stream_write_pkg;
   // command code decoded as stream dma write
   localparam logic [7:0] CMD_STREAM_DMA_WRITE = 8'h3A;
   // apb byte addresses of the task-file and side registers
   localparam logic [7:0] ADDR_FEATURE = 8'h04; // write feature, read error
   localparam logic [7:0] ADDR_SECTOR_COUNT = 8'h08;
   localparam logic [7:0] ADDR_LBA_LOW = 8'h0C;
   localparam logic [7:0] ADDR_LBA_MID = 8'h10;
   localparam logic [7:0] ADDR_LBA_HIGH = 8'h14;
   localparam logic [7:0] ADDR_DEVICE_SELECT = 8'h18;
   localparam logic [7:0] ADDR_COMMAND = 8'h1C; // write command, read status
   localparam logic [7:0] ADDR_DEVICE_CONTROL = 8'h20;
   localparam logic [7:0] ADDR_ERROR_LOG = 8'h24;
   localparam logic [7:0] ADDR_STREAM_DEFAULT = 8'h28;
   // feature byte fields
   localparam int FEAT_URGENT = 7;
   localparam int FEAT_WC = 6;
   localparam int FEAT_FLUSH = 5;
   localparam int FEAT_RESUME = 4;
   localparam int FEAT_SID_MSB = 2;
   // error register fields
   localparam int ERR_INTERFACE_CHECKSUM_ERROR = 7;
   localparam int ERR_SECTOR_NOT_FOUND = 4;
   localparam int ERR_COMMAND_ABORTED = 2;
   localparam int ERR_COMPLETION_TIMEOUT_FLAG = 0;
   // status register fields
   localparam int ST_BSY = 7;
   localparam int ST_RDY = 6;
   localparam int ST_SE = 5;
   localparam int ST_ERR = 0;
   // device control field and stream default write layout
   localparam int DEVCTL_HOB = 7;
   localparam int SDEF_SID_LSB = 8;
   // reset values
   localparam logic [7:0] TF_RESET = 8'h00;
   localparam logic [7:0] STATUS_IDLE = 8'h40;
   // timing: limit unit and clock rate
   localparam int CLK_MHZ = 250;
   localparam int US_CYCLES = CLK_MHZ; // one microsecond at 250 MHz
   localparam logic [16:0] SECTORS_ZERO = 17'h10000;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_XFER = 2'b01,
      ST_FLUSH = 2'b10
   } state_t;
endpackage

// >>> design/stream_dma_write_command.sv
// stream dma write command interpreter with apb task-file registers
`timescale 1ns/1ps
// Overview of operation
// - command code 3Ah starts stream dma write
// - sector data moves only over dma
// - carry out requested options before completion
// - write-continuous bit 6: errors never abort
// - continuous errors: full transfer, stream error set
// - continuous error kind goes to error log
// - time limit expiry stops command, busy clears
// - expiry sets completion timeout in error log
// - always try moving all data within limit
// - urgent bit 7: finish fast, within limit
// - sixteen bit count, zero means 65536
// - low three feature bits pick the stream
// - limit is previous feature times unit
// - flush bit 5 commits stream before completion
module stream_dma_write_command
   import stream_write_pkg::*;
#(
   parameter int WORDS_PER_SECTOR = 256,
   parameter int LIMIT_UNIT_US = 10,
   parameter int MIN_LIMIT_US = 100
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // dma data in from host, one 16-bit word per beat
   input wire logic dma_valid,
   input wire logic [15:0] dma_data,
   input wire logic dma_crc_err,
   output logic dma_ready,
   output logic dma_active,
   // media write side
   output logic media_valid,
   output logic [15:0] media_data,
   output logic [47:0] media_lba,
   output logic [2:0] media_stream,
   output logic media_urgent,
   input wire logic media_ready,
   input wire logic media_not_found,
   output logic flush_req,
   input wire logic flush_done,
   // completion pulse
   output logic cmd_done
);
   localparam int WW = $clog2(WORDS_PER_SECTOR);
   initial begin
      if (WORDS_PER_SECTOR < 2 || (1 << WW) != WORDS_PER_SECTOR)
         $error("words per sector must be a power of two");
      if (MIN_LIMIT_US < 1 || LIMIT_UNIT_US < 1)
         $error("limit unit and minimum must be positive");
   end
   // two-deep task-file bytes: [0] current, [1] previous
   logic [1:0][7:0] feat_q;
   logic [1:0][7:0] cnt_q;
   logic [1:0][7:0] lo_q;
   logic [1:0][7:0] mid_q;
   logic [1:0][7:0] hi_q;
   logic [7:0] devsel_q, devctl_q, error_q, status_q, log_q;
   logic [7:0] sdef_q [8];
   state_t state_q;
   logic [16:0] left_q;
   logic [WW-1:0] word_q;
   logic [47:0] lba_q;
   logic [23:0] limit_q, us_q;
   logic [7:0] pre_q;
   logic limit_on_q, wc_q, err_seen_q, done_q;
   logic [7:0] opt_q;
   // apb decode
   logic wr_en, mapped, high_order_byte_select, start, timeout, beat, keep, last_word;
   assign wr_en = psel && penable && pwrite;
   assign high_order_byte_select = devctl_q[DEVCTL_HOB];
   assign mapped = paddr inside {ADDR_FEATURE, ADDR_SECTOR_COUNT,
      ADDR_LBA_LOW, ADDR_LBA_MID, ADDR_LBA_HIGH, ADDR_DEVICE_SELECT,
      ADDR_COMMAND, ADDR_DEVICE_CONTROL, ADDR_ERROR_LOG,
      ADDR_STREAM_DEFAULT};
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   // task file is locked while busy
   assign start = wr_en && paddr == ADDR_COMMAND && state_q == ST_IDLE;
   // limit in microseconds: byte times unit, raised to the minimum
   function automatic logic [23:0] limit_us(input logic [7:0] val);
      logic [23:0] t;
      t = 24'(val) * 24'(LIMIT_UNIT_US);
      if (t < 24'(MIN_LIMIT_US))
         t = 24'(MIN_LIMIT_US);
      return t;
   endfunction
   // shift a two-deep byte on write
   function automatic logic [15:0] push(input logic [7:0] cur,
      input logic [7:0] nw);
      return {cur, nw};
   endfunction
   // task-file byte registers, writes ignored while busy
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         feat_q <= {2{TF_RESET}};
         cnt_q <= {2{TF_RESET}};
         lo_q <= {2{TF_RESET}};
         mid_q <= {2{TF_RESET}};
         hi_q <= {2{TF_RESET}};
         devsel_q <= TF_RESET;
      end else if (wr_en && state_q == ST_IDLE) begin
         unique case (paddr)
            ADDR_FEATURE: feat_q <= push(feat_q[0], pwdata[7:0]);
            ADDR_SECTOR_COUNT: cnt_q <= push(cnt_q[0], pwdata[7:0]);
            ADDR_LBA_LOW: lo_q <= push(lo_q[0], pwdata[7:0]);
            ADDR_LBA_MID: mid_q <= push(mid_q[0], pwdata[7:0]);
            ADDR_LBA_HIGH: hi_q <= push(hi_q[0], pwdata[7:0]);
            ADDR_DEVICE_SELECT: devsel_q <= pwdata[7:0];
            default: ;
         endcase
      end
   end
   // device control and per-stream default limits
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         devctl_q <= TF_RESET;
         for (int i = 0; i < 8; i++)
            sdef_q[i] <= TF_RESET;
      end else if (wr_en) begin
         if (paddr == ADDR_DEVICE_CONTROL)
            devctl_q <= pwdata[7:0];
         if (paddr == ADDR_STREAM_DEFAULT)
            sdef_q[pwdata[SDEF_SID_LSB+:3]] <= pwdata[7:0];
      end
   end
   // read mux, previous bytes shown while high-order select is set
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst)
         prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite) begin
         unique case (paddr)
            ADDR_FEATURE: prdata <= {24'h0, error_q};
            ADDR_SECTOR_COUNT: prdata <= {24'h0, cnt_q[high_order_byte_select]};
            ADDR_LBA_LOW: prdata <= {24'h0, lo_q[high_order_byte_select]};
            ADDR_LBA_MID: prdata <= {24'h0, mid_q[high_order_byte_select]};
            ADDR_LBA_HIGH: prdata <= {24'h0, hi_q[high_order_byte_select]};
            ADDR_DEVICE_SELECT: prdata <= {24'h0, devsel_q};
            ADDR_COMMAND: prdata <= {24'h0, status_q};
            ADDR_DEVICE_CONTROL: prdata <= {24'h0, devctl_q};
            ADDR_ERROR_LOG: prdata <= {24'h0, log_q};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // microsecond prescaler and limit counter, held clear while idle
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pre_q <= 8'h00;
         us_q <= 24'h000000;
      end else if (state_q == ST_IDLE) begin
         pre_q <= 8'h00;
         us_q <= 24'h000000;
      end else if (pre_q == 8'(US_CYCLES - 1)) begin
         pre_q <= 8'h00;
         us_q <= us_q + 24'h000001; // timed from command write
      end else
         pre_q <= pre_q + 8'h01;
   end
   assign timeout = limit_on_q && state_q != ST_IDLE && us_q >= limit_q;
   // dma beat handshake; stalls on media back-pressure and at expiry
   assign dma_active = state_q == ST_XFER; // data only by dma
   assign dma_ready = state_q == ST_XFER && (!media_valid || media_ready)
      && !timeout;
   assign beat = dma_valid && dma_ready;
   assign keep = beat && (wc_q || !(dma_crc_err || media_not_found));
   assign last_word = word_q == WW'(WORDS_PER_SECTOR - 1);
   // media word register, an errored word only passes in continuous mode
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         media_valid <= 1'b0;
         media_data <= 16'h0000;
      end else if (keep) begin
         media_valid <= 1'b1;
         media_data <= dma_data;
      end else if (media_ready)
         media_valid <= 1'b0;
   end
   // command sequencer
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= ST_IDLE;
         left_q <= 17'h00000;
         word_q <= '0;
         lba_q <= 48'h0;
         limit_q <= 24'h000000;
         limit_on_q <= 1'b0;
         opt_q <= TF_RESET;
         wc_q <= 1'b0;
         err_seen_q <= 1'b0;
         error_q <= TF_RESET;
         status_q <= STATUS_IDLE;
         log_q <= TF_RESET;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (start) begin
            error_q <= TF_RESET;
            log_q <= TF_RESET;
            err_seen_q <= 1'b0;
            if (pwdata[7:0] == CMD_STREAM_DMA_WRITE) begin
               state_q <= ST_XFER;
               status_q <= STATUS_IDLE | (8'h01 << ST_BSY);
               opt_q <= feat_q[0];
               wc_q <= feat_q[0][FEAT_WC];
               // zero count means 65536 sectors
               left_q <= {cnt_q[1], cnt_q[0]} == 16'h0000 ? SECTORS_ZERO
                  : {1'b0, cnt_q[1], cnt_q[0]};
               word_q <= '0;
               lba_q <= {hi_q[1], mid_q[1], lo_q[1], hi_q[0], mid_q[0],
                  lo_q[0]};
               // previous feature byte, else stream default
               if (feat_q[1] != 8'h00) begin
                  limit_q <= limit_us(feat_q[1]);
                  limit_on_q <= 1'b1;
               end else begin
                  limit_q <= limit_us(sdef_q[feat_q[0][FEAT_SID_MSB:0]]);
                  limit_on_q <= sdef_q[feat_q[0][FEAT_SID_MSB:0]] != 8'h00;
               end
            end else begin
               error_q <= 8'h01 << ERR_COMMAND_ABORTED;
               status_q <= STATUS_IDLE | (8'h01 << ST_ERR);
               done_q <= 1'b1;
            end
         end else if (timeout) begin
            // stop at once, busy clears
            state_q <= ST_IDLE;
            log_q <= log_q | (8'h01 << ERR_COMPLETION_TIMEOUT_FLAG);
            error_q <= error_q | (8'h01 << ERR_COMPLETION_TIMEOUT_FLAG);
            status_q <= wc_q ? STATUS_IDLE | (8'h01 << ST_SE)
               : STATUS_IDLE | (8'h01 << ST_ERR);
            done_q <= 1'b1;
         end else if (state_q == ST_XFER) begin
            if (beat && (dma_crc_err || media_not_found)) begin
               if (wc_q) begin
                  // keep going, kind goes to the log only
                  err_seen_q <= 1'b1;
                  log_q <= log_q | (dma_crc_err ? 8'h01 << ERR_INTERFACE_CHECKSUM_ERROR
                     : 8'h01 << ERR_SECTOR_NOT_FOUND);
               end else begin
                  // abort at failing sector without continuous mode
                  state_q <= ST_IDLE;
                  error_q <= (dma_crc_err ? 8'h01 << ERR_INTERFACE_CHECKSUM_ERROR
                     : 8'h01 << ERR_SECTOR_NOT_FOUND) | (8'h01 << ERR_COMMAND_ABORTED);
                  status_q <= STATUS_IDLE | (8'h01 << ST_ERR);
                  done_q <= 1'b1;
               end
            end
            if (keep) begin
               word_q <= word_q + 1'b1;
               if (last_word) begin
                  lba_q <= lba_q + 48'h1;
                  left_q <= left_q - 17'h00001; // one sector moved
                  if (left_q == 17'h00001)
                     state_q <= opt_q[FEAT_FLUSH] ? ST_FLUSH : ST_IDLE;
                  if (left_q == 17'h00001 && !opt_q[FEAT_FLUSH]) begin
                     status_q <= (err_seen_q || dma_crc_err ||
                        media_not_found) ? STATUS_IDLE | (8'h01 << ST_SE)
                        : STATUS_IDLE;
                     done_q <= 1'b1;
                  end
               end
            end
         end else if (state_q == ST_FLUSH && flush_done && !media_valid) begin
            // stream committed before completion
            state_q <= ST_IDLE;
            status_q <= err_seen_q ? STATUS_IDLE | (8'h01 << ST_SE)
               : STATUS_IDLE;
            done_q <= 1'b1;
         end
      end
   end
   // media side options and completion
   assign flush_req = state_q == ST_FLUSH;
   assign media_lba = lba_q;
   assign media_stream = opt_q[FEAT_SID_MSB:0];
   assign media_urgent = opt_q[FEAT_URGENT] && state_q != ST_IDLE;
   assign cmd_done = done_q;
   // checks
   sequence s_start_cmd;
      start && pwdata[7:0] == CMD_STREAM_DMA_WRITE;
   endsequence
   sequence s_busy;
      status_q[ST_BSY] && state_q == ST_XFER;
   endsequence
   a_cmd_decode: assert property (@(posedge clk) disable iff (sys_rst)
      s_start_cmd |=> s_busy)
      else $error("stream write command not decoded");
   a_other_cmd_abort: assert property (@(posedge clk) disable iff (sys_rst)
      start && pwdata[7:0] != CMD_STREAM_DMA_WRITE |=>
      error_q[ERR_COMMAND_ABORTED] && status_q[ST_ERR] && cmd_done)
      else $error("unknown command not aborted");
   a_dma_only: assert property (@(posedge clk) disable iff (sys_rst)
      dma_ready |-> state_q == ST_XFER)
      else $error("data taken outside dma phase");
   a_wc_no_abort: assert property (@(posedge clk) disable iff (sys_rst)
      state_q == ST_XFER && wc_q && beat && dma_crc_err && !timeout &&
      !(last_word && left_q == 17'h00001) |=>
      state_q == ST_XFER && log_q[ERR_INTERFACE_CHECKSUM_ERROR])
      else $error("continuous mode stopped on error");
   a_wc_end_status: assert property (@(posedge clk) disable iff (sys_rst)
      cmd_done && wc_q && err_seen_q && !log_q[ERR_COMPLETION_TIMEOUT_FLAG] |->
      status_q[ST_SE] && !status_q[ST_ERR] && !status_q[ST_BSY] &&
      error_q == 8'h00)
      else $error("continuous error ending status wrong");
   a_timeout_end: assert property (@(posedge clk) disable iff (sys_rst)
      timeout && !start |=> state_q == ST_IDLE && !status_q[ST_BSY] &&
      log_q[ERR_COMPLETION_TIMEOUT_FLAG] && error_q[ERR_COMPLETION_TIMEOUT_FLAG] && cmd_done)
      else $error("time limit expiry not reported");
   a_count_zero: assert property (@(posedge clk) disable iff (sys_rst)
      s_start_cmd and (cnt_q[0] == 8'h00 && cnt_q[1] == 8'h00) |=>
      left_q == SECTORS_ZERO)
      else $error("zero count not taken as 65536");
   a_flush_first: assert property (@(posedge clk) disable iff (sys_rst)
      cmd_done && opt_q[FEAT_FLUSH] && $past(state_q) == ST_XFER &&
      !$past(timeout) |-> status_q[ST_ERR])
      else $error("completion reported before flush");
   a_limit_floor: assert property (@(posedge clk) disable iff (sys_rst)
      limit_on_q |-> limit_q >= 24'(MIN_LIMIT_US))
      else $error("time limit below device minimum");
   a_error_bits: assert property (@(posedge clk) disable iff (sys_rst)
      (error_q & 8'h6A) == 8'h00 && !status_q[4])
      else $error("reserved error or status bit set");
endmodule // stream_dma_write_command

// >>> verif/host_dma_model.sv
// host dma source and media sink model for the stream write block
`timescale 1ns/1ps
module host_dma_model (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // test controls
   input wire logic send,
   input wire logic slow,
   input wire logic [7:0] crc_beat,
   // dma toward the device
   input wire logic dma_ready,
   output logic dma_valid,
   output logic [15:0] dma_data,
   output logic dma_crc_err,
   // media behind the device
   input wire logic media_valid,
   input wire logic flush_req,
   output logic media_ready,
   output logic media_not_found,
   output logic flush_done,
   // counts seen
   output int beats,
   output int media_words
);
   logic tick_q;
   logic [2:0] flush_cnt_q;
   logic [15:0] word;
   // data only as dma beats; inverted pattern while not offered
   assign word = {8'hA5, beats[7:0]};
   assign dma_valid = send;
   assign dma_data = send ? word : ~word;
   assign dma_crc_err = send && (beats[7:0] == crc_beat);
   assign media_ready = slow ? tick_q : 1'b1;
   assign media_not_found = 1'b0;
   assign flush_done = (flush_cnt_q == 3'h5);
   // beat and media counts, flush acknowledged after a few cycles
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         beats <= 0;
         media_words <= 0;
         tick_q <= 1'b0;
         flush_cnt_q <= 3'h0;
      end else begin
         tick_q <= ~tick_q;
         if (dma_valid && dma_ready) beats <= beats + 1;
         if (media_valid && media_ready) media_words <= media_words + 1;
         if (!flush_req) flush_cnt_q <= 3'h0;
         else if (flush_cnt_q != 3'h5) flush_cnt_q <= flush_cnt_q + 3'h1;
      end
   end
endmodule // host_dma_model

// >>> verif/stream_dma_write_command_tb.sv
// testbench for the stream dma write command block
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module stream_dma_write_command_tb;
   import stream_write_pkg::*;
   logic clk = 1'b0, sys_rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, last_err;
   logic send = 1'b0, slow = 1'b0, saw_flush = 1'b0, saw_done = 1'b0;
   logic [7:0] crc_beat = 8'hFF;
   logic dma_valid, dma_crc_err, dma_ready, dma_active, media_valid;
   logic media_ready, media_not_found, flush_req, flush_done, cmd_done;
   logic media_urgent;
   logic [15:0] dma_data, media_data;
   logic [47:0] media_lba;
   logic [2:0] media_stream;
   int beats, media_words, failures = 0, n_checks = 0, cyc = 0, b0, m0, n;
   // 250 MHz clock
   always #2 clk = ~clk;
   stream_dma_write_command #(.WORDS_PER_SECTOR(4), .LIMIT_UNIT_US(1),
      .MIN_LIMIT_US(2)) uut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .dma_valid(dma_valid), .dma_data(dma_data), .dma_crc_err(dma_crc_err),
      .dma_ready(dma_ready), .dma_active(dma_active),
      .media_valid(media_valid), .media_data(media_data),
      .media_lba(media_lba), .media_stream(media_stream),
      .media_urgent(media_urgent), .media_ready(media_ready),
      .media_not_found(media_not_found), .flush_req(flush_req),
      .flush_done(flush_done), .cmd_done(cmd_done));
   host_dma_model host (.clk(clk), .sys_rst(sys_rst), .send(send),
      .slow(slow), .crc_beat(crc_beat), .dma_ready(dma_ready),
      .dma_valid(dma_valid), .dma_data(dma_data), .dma_crc_err(dma_crc_err),
      .media_valid(media_valid), .flush_req(flush_req),
      .media_ready(media_ready), .media_not_found(media_not_found),
      .flush_done(flush_done), .beats(beats), .media_words(media_words));
   // flush seen flag and cycle ceiling
   always @(posedge clk) begin
      if (flush_req === 1'b1) saw_flush <= 1'b1;
      if (cmd_done === 1'b1) saw_done <= 1'b1;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         final_report();
      end
   end
   // one apb transfer, released with an idle cycle after it
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      apb(1'b1, a, {24'h0, d}, r);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      apb(1'b0, a, 32'h0, r);
      `CHK(r, exp)
   endtask
   // loads feature and count pairs, then issues the command
   task automatic issue(input logic [7:0] fp, input logic [7:0] fc,
                        input logic [7:0] cnt, input logic [7:0] cmd);
      wr(ADDR_FEATURE, fp);
      wr(ADDR_FEATURE, fc);
      wr(ADDR_SECTOR_COUNT, 8'h00);
      wr(ADDR_SECTOR_COUNT, cnt);
      b0 = beats;
      m0 = media_words;
      saw_flush <= 1'b0;
      saw_done <= 1'b0;
      wr(ADDR_COMMAND, cmd);
   endtask
   // waits for the latched completion pulse, counting cycles
   task automatic wait_done();
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (saw_done !== 1'b1 && n < 5000);
      if (n >= 5000) failures++;
      @(posedge clk);
   endtask
   task automatic final_report();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      // idle state after reset, unmapped read refused
      rd(ADDR_COMMAND, 32'h40);
      rd(ADDR_FEATURE, 32'h00);
      rd(8'h30, 32'h00);
      `CHK(last_err, 1'b1)
      // unknown command code is aborted
      issue(8'h00, 8'h00, 8'h01, 8'h35);
      wait_done();
      rd(ADDR_FEATURE, 32'h04);
      rd(ADDR_COMMAND, 32'h41);
      // urgent flushed two sector write on stream 3, slow media
      slow <= 1'b1;
      send <= 1'b1;
      issue(8'h00, 8'hA3, 8'h02, CMD_STREAM_DMA_WRITE);
      rd(ADDR_COMMAND, 32'hC0);
      `CHK(media_stream, 3'h3)
      `CHK(media_urgent, 1'b1)
      `CHK(dma_active, 1'b1)
      wait_done();
      `CHK(beats - b0, 8)
      `CHK(media_words - m0, 8)
      `CHK(saw_flush, 1'b1)
      `CHK(media_lba, 48'h000000000002)
      rd(ADDR_COMMAND, 32'h40);
      // checksum error without continuous mode aborts at once
      slow <= 1'b0;
      crc_beat <= 8'(beats + 2);
      issue(8'h00, 8'h01, 8'h01, CMD_STREAM_DMA_WRITE);
      wait_done();
      `CHK(beats - b0, 3)
      `CHK(media_words - m0, 2)
      rd(ADDR_FEATURE, 32'h84);
      rd(ADDR_COMMAND, 32'h41);
      // continuous mode keeps going past a checksum error
      crc_beat <= 8'(beats + 1);
      issue(8'h00, 8'h40, 8'h01, CMD_STREAM_DMA_WRITE);
      wait_done();
      `CHK(beats - b0, 4)
      `CHK(media_words - m0, 4)
      `CHK(media_data, 16'hA50E)
      rd(ADDR_COMMAND, 32'h60);
      rd(ADDR_FEATURE, 32'h00);
      rd(ADDR_ERROR_LOG, 32'h80);
      // stalled host: 2 us limit expires in continuous mode
      send <= 1'b0;
      crc_beat <= 8'hFF;
      issue(8'h02, 8'h40, 8'h01, CMD_STREAM_DMA_WRITE);
      wait_done();
      `CHK(n > 480 && n < 510, 1'b1)
      rd(ADDR_COMMAND, 32'h60);
      rd(ADDR_FEATURE, 32'h01);
      rd(ADDR_ERROR_LOG, 32'h01);
      // zero count means 65536 sectors; the 2 us limit ends it early
      issue(8'h02, 8'h00, 8'h00, CMD_STREAM_DMA_WRITE);
      wait_done();
      `CHK(n > 480 && n < 510, 1'b1)
      rd(ADDR_COMMAND, 32'h41);
      rd(ADDR_FEATURE, 32'h01);
      final_report();
   end
endmodule // stream_dma_write_command_tb
